/* design/sdod_top.sv */
`include "sdod_consts.svh"
`default_nettype none

// Behaviour
// - With the asynchronous serial mode pin high, the word framer and 8b10b decoder sit in the data path.
// - In that mode each decoded byte goes out one nibble at a time on lanes 0 to 3.
// - In that mode lane 4 is high exactly while the nibble shown belongs to the idle character.
// - In DDR clock mode the low nibble goes with the rising output clock edge and the high nibble with the next falling edge.
// - Up to 110 consecutive commas may be needed before framing holds; until then output may be wrong.
// - Power-on reset restores every register and starts acquisition on serial input zero.
// - While the reset pin is low the device stays reset, and it runs again once the pin is high.
// - A soft reset write restores all registers except the device bus address register.
// - The output swing defaults to small and a larger one is chosen in the swing register.
// - The timing register shifts the clock against the data and picks a DDR or DDR/2 clock.
// - The input select pin picks the serial input that feeds recovery and the loopthrough.
// - Switching between equal-rate inputs normally keeps lock and corrupts only a few words.
// - Loss of lock holds the active-low lock output high until lock returns.
module sdod_top
    import sdod_pkg::*;
#(
    parameter int HALF_CYC  = `SDOD_HALF_CYC,
    parameter int COMMA_RUN = `SDOD_COMMA_RUN
)(
    input  wire logic       I_CLK,                // core clock, 250 MHz
    input  wire logic       I_RST,                // power-on reset, sync, high
    input  wire logic       I_RESET_N,            // reset pin, async, low
    input  wire logic       I_ASI_MODE,           // async serial mode pin
    input  wire logic       I_SERIAL_INPUT_SELECT, // input select pin
    input  wire logic [9:0] I_SERIAL_INPUT_ZERO,  // recovered word, input 0
    input  wire logic [9:0] I_SERIAL_INPUT_ONE,   // recovered word, input 1
    input  wire logic       I_WORD_VLD,           // recovered word strobe
    input  wire logic       I_CDR_LOCK,           // recovery lock, async
    input  wire logic       I_REG_WR,             // register write strobe
    input  wire logic [7:0] I_REG_ADDR,           // register address
    input  wire logic [7:0] I_REG_WDATA,          // register write data
    output logic      [7:0] O_REG_RDATA,          // register read data
    output logic      [7:0] O_DEV_ADDR,           // device bus address
    output logic      [4:0] O_LVDS_DATA,          // five data lanes
    output logic            O_LVDS_OUTPUT_CLOCK,  // lvds output clock
    output logic            O_LVDS_SWING_HI,      // large swing select
    output logic      [9:0] O_LOOP_WORD,          // loopthrough word
    output logic            O_LOCK_N,             // lock, low active
    output logic            O_FRAMED              // decoder framed
);
    // ------------------------------------------------------------
    // pin synchronisers and resets
    // ------------------------------------------------------------
    logic rstn_s1, rstn_s2, asi_s1, asi_s2, sel_s1, sel_s2, lock_s1, lock_s2;
    logic asi_q, sel_q, soft_q;
    logic [7:0] devaddr_q, swing_q, timing_q;

    // two flops per asynchronous pin: reset, mode, select and lock
    always_ff @(posedge I_CLK)
    begin
        rstn_s1 <= I_RESET_N;
        rstn_s2 <= rstn_s1;
        asi_s1  <= I_ASI_MODE;
        asi_s2  <= asi_s1;
        sel_s1  <= I_SERIAL_INPUT_SELECT;
        sel_s2  <= sel_s1;
        lock_s1 <= I_CDR_LOCK;
        lock_s2 <= lock_s1;
    end

    wire rst_core = I_RST || !rstn_s2;
    wire reg_rst  = rst_core || soft_q;
    wire sel_chg  = sel_q != sel_s2;
    wire wr_soft  = I_REG_WR && (I_REG_ADDR == `SDOD_REG_SOFT_RST);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // address register survives soft reset
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
            devaddr_q <= `SDOD_DEVADDR_RST;
        else if (I_REG_WR && I_REG_ADDR == `SDOD_REG_DEVADDR)
            devaddr_q <= I_REG_WDATA;
    end

    // swing and timing registers
    always_ff @(posedge I_CLK)
    begin
        if (reg_rst)
        begin
            swing_q  <= `SDOD_SWING_RST;
            timing_q <= `SDOD_TIMING_RST;
        end
        else if (I_REG_WR && I_REG_ADDR == `SDOD_REG_SWING)
            swing_q <= I_REG_WDATA;
        else if (I_REG_WR && I_REG_ADDR == `SDOD_REG_TIMING)
            timing_q <= I_REG_WDATA;
    end

    // mode, input select and soft reset pulse
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
        begin
            asi_q  <= 1'b0;
            sel_q  <= 1'b0;
            soft_q <= 1'b0;
        end
        else
        begin
            asi_q  <= asi_s2;
            sel_q  <= sel_s2;
            soft_q <= wr_soft;
        end
    end

    // read decode
    logic [7:0] rdata_d;
    always_comb
    begin
        rdata_d = 8'h00;
        if (I_REG_ADDR == `SDOD_REG_DEVADDR)
            rdata_d = devaddr_q;
        else if (I_REG_ADDR == `SDOD_REG_SWING)
            rdata_d = swing_q;
        else if (I_REG_ADDR == `SDOD_REG_TIMING)
            rdata_d = timing_q;
        else if (I_REG_ADDR == `SDOD_REG_STATUS)
        begin
            rdata_d[`SDOD_STAT_SEL_BIT]    = sel_q;
            rdata_d[`SDOD_STAT_FRAMED_BIT] = O_FRAMED;
            rdata_d[`SDOD_STAT_LOCK_BIT]   = !O_LOCK_N;
        end
    end

    // ------------------------------------------------------------
    // input mux, loopthrough, lock
    // ------------------------------------------------------------
    wire [9:0] sel_word = sel_q ? I_SERIAL_INPUT_ONE : I_SERIAL_INPUT_ZERO;

    // registered outputs of the control side
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
        begin
            O_REG_RDATA <= 8'h00;
            O_LOOP_WORD <= 10'h000;
            O_LOCK_N    <= 1'b1;
        end
        else
        begin
            O_REG_RDATA <= rdata_d;
            if (I_WORD_VLD)
                O_LOOP_WORD <= sel_word;
            O_LOCK_N <= !lock_s2;
        end
    end

    assign O_DEV_ADDR      = devaddr_q;
    assign O_LVDS_SWING_HI = swing_q[`SDOD_SWING_HI_BIT];

    // ------------------------------------------------------------
    // framer and 8b10b decoder
    // ------------------------------------------------------------
    logic [9:0] fr_word;
    logic       fr_vld;

    // framer restarts after reset or an input switch
    sdod_comma_framer #(.COMMA_RUN(COMMA_RUN)) u_framer (
        .i_clk    (I_CLK),
        .i_rst    (rst_core || sel_chg),
        .i_word   (sel_word),
        .i_vld    (I_WORD_VLD && asi_q),
        .o_word   (fr_word),
        .o_vld    (fr_vld),
        .o_framed (O_FRAMED)
    );

    // six-bit group to EDCBA
    function automatic logic [4:0] dec6(input logic [5:0] c);
        case (c)
            6'h27, 6'h18: dec6 = 5'd0;   6'h1d, 6'h22: dec6 = 5'd1;
            6'h2d, 6'h12: dec6 = 5'd2;   6'h31:        dec6 = 5'd3;
            6'h35, 6'h0a: dec6 = 5'd4;   6'h29:        dec6 = 5'd5;
            6'h19:        dec6 = 5'd6;   6'h38, 6'h07: dec6 = 5'd7;
            6'h39, 6'h06: dec6 = 5'd8;   6'h25:        dec6 = 5'd9;
            6'h15:        dec6 = 5'd10;  6'h34:        dec6 = 5'd11;
            6'h0d:        dec6 = 5'd12;  6'h2c:        dec6 = 5'd13;
            6'h1c:        dec6 = 5'd14;  6'h17, 6'h28: dec6 = 5'd15;
            6'h1b, 6'h24: dec6 = 5'd16;  6'h23:        dec6 = 5'd17;
            6'h13:        dec6 = 5'd18;  6'h32:        dec6 = 5'd19;
            6'h0b:        dec6 = 5'd20;  6'h2a:        dec6 = 5'd21;
            6'h1a:        dec6 = 5'd22;  6'h3a, 6'h05: dec6 = 5'd23;
            6'h33, 6'h0c: dec6 = 5'd24;  6'h26:        dec6 = 5'd25;
            6'h16:        dec6 = 5'd26;  6'h36, 6'h09: dec6 = 5'd27;
            6'h0e, 6'h0f, 6'h30: dec6 = 5'd28;
            6'h2e, 6'h11: dec6 = 5'd29;  6'h1e, 6'h21: dec6 = 5'd30;
            6'h2b, 6'h14: dec6 = 5'd31;
            default:      dec6 = 5'd0;
        endcase
    endfunction

    // four-bit group to HGF
    function automatic logic [2:0] dec4(input logic [3:0] c);
        case (c)
            4'hb, 4'h4:             dec4 = 3'd0;
            4'h9:                   dec4 = 3'd1;
            4'h5:                   dec4 = 3'd2;
            4'hc, 4'h3:             dec4 = 3'd3;
            4'hd, 4'h2:             dec4 = 3'd4;
            4'ha:                   dec4 = 3'd5;
            4'h6:                   dec4 = 3'd6;
            4'he, 4'h1, 4'h7, 4'h8: dec4 = 3'd7;
            default:                dec4 = 3'd0;
        endcase
    endfunction

    // control symbols of positive disparity carry an inverted tail
    wire       k28    = (fr_word[9:4] == 6'h0f) || (fr_word[9:4] == 6'h30);
    wire [3:0] tail   = (fr_word[9:4] == 6'h30) ? ~fr_word[3:0] : fr_word[3:0];
    wire [7:0] byte_d = {dec4(tail), dec6(fr_word[9:4])};
    wire       idle   = k28 && (byte_d == `SDOD_IDLE_BYTE);

    // lane word: low five bits go on the rise, high five on the fall
    wire [9:0] src_word = asi_q ? {idle, byte_d[7:4], idle, byte_d[3:0]}
                                : sel_word;
    wire       src_vld  = asi_q ? fr_vld : I_WORD_VLD;

    // ------------------------------------------------------------
    // ddr output stage
    // ------------------------------------------------------------
    logic [7:0]  div_q;
    logic        pend_q, tgl_q;
    logic [9:0]  stg_q, hold_q;
    logic [2:0]  dly_q;
    sdod_phase_t state_q;

    wire       div_en   = div_q == 8'(HALF_CYC - 1);
    wire       load     = div_en && pend_q && (state_q != PH_RISE);
    wire       ddr2     = timing_q[`SDOD_TIM_DDR2_BIT];
    wire [1:0] dly_sel  = timing_q[`SDOD_TIM_DLY_LSB +: 2];
    wire       clk_src  = ddr2 ? tgl_q : (state_q == PH_RISE);
    wire [3:0] clk_taps = {dly_q, clk_src};
    wire [4:0] lanes_d  = (state_q == PH_RISE) ? hold_q[4:0]
                        : (state_q == PH_FALL) ? hold_q[9:5] : 5'h00;

    // half period divider and staging of the next word
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
        begin
            div_q  <= 8'h00;
            pend_q <= 1'b0;
            stg_q  <= 10'h000;
        end
        else
        begin
            div_q <= div_en ? 8'h00 : div_q + 8'h01;
            if (src_vld)
            begin
                stg_q  <= src_word;
                pend_q <= 1'b1;
            end
            else if (load)
                pend_q <= 1'b0;
        end
    end

    // rise and fall phases, one per divider pulse
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
        begin
            state_q <= PH_IDLE;
            hold_q  <= 10'h000;
            tgl_q   <= 1'b0;
        end
        else if (div_en)
        begin
            if (load)
            begin
                hold_q <= stg_q;
                tgl_q  <= !tgl_q;
            end
            case (state_q)
                PH_IDLE: state_q <= pend_q ? PH_RISE : PH_IDLE;
                PH_RISE: state_q <= PH_FALL;
                PH_FALL: state_q <= pend_q ? PH_RISE : PH_IDLE;
                default: state_q <= PH_IDLE;
            endcase
        end
    end

    // clock delay line and registered lanes
    always_ff @(posedge I_CLK)
    begin
        if (rst_core)
        begin
            dly_q               <= 3'h0;
            O_LVDS_DATA         <= 5'h00;
            O_LVDS_OUTPUT_CLOCK <= 1'b0;
        end
        else
        begin
            dly_q               <= clk_taps[2:0];
            O_LVDS_DATA         <= lanes_d;
            O_LVDS_OUTPUT_CLOCK <= clk_taps[dly_sel];
        end
    end

    property p_lo_on_rise;
        @(posedge I_CLK) disable iff (rst_core)
        (state_q == PH_RISE && asi_q) |=> O_LVDS_DATA[3:0] == $past(hold_q[3:0]);
    endproperty
    a_lo_on_rise: assert property (p_lo_on_rise) else $error("low nibble missing at rise");

    property p_hi_on_fall;
        @(posedge I_CLK) disable iff (rst_core)
        (state_q == PH_FALL && asi_q) |=> O_LVDS_DATA[3:0] == $past(hold_q[8:5]);
    endproperty
    a_hi_on_fall: assert property (p_hi_on_fall) else $error("high nibble missing at fall");

    property p_idle_both_phases;
        @(posedge I_CLK) disable iff (rst_core)
        (fr_vld && asi_q) |=> (stg_q[4] == stg_q[9]) && (stg_q[4] == $past(k28 && byte_d == 8'hbc));
    endproperty
    a_idle_both_phases: assert property (p_idle_both_phases) else $error("idle lane wrong");

    property p_pin_reset;
        @(posedge I_CLK) disable iff (I_RST)
        (!I_RESET_N)[*3] |=> (swing_q == `SDOD_SWING_RST) && (timing_q == `SDOD_TIMING_RST) && !sel_q;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");

    property p_soft_reset;
        @(posedge I_CLK) disable iff (rst_core)
        wr_soft |=> ##1 (swing_q == `SDOD_SWING_RST) && (timing_q == `SDOD_TIMING_RST) && $stable(devaddr_q);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_reset_defaults;
        @(posedge I_CLK)
        rst_core |=> !O_LVDS_SWING_HI && !sel_q && !asi_q;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

    property p_ddr2_one_edge;
        @(posedge I_CLK) disable iff (rst_core)
        (ddr2 && div_en && state_q == PH_RISE) |=> $stable(clk_src);
    endproperty
    a_ddr2_one_edge: assert property (p_ddr2_one_edge) else $error("half rate clock toggled twice");

    property p_loop_select;
        @(posedge I_CLK) disable iff (rst_core)
        I_WORD_VLD |=> O_LOOP_WORD == $past(sel_q ? I_SERIAL_INPUT_ONE : I_SERIAL_INPUT_ZERO);
    endproperty
    a_loop_select: assert property (p_loop_select) else $error("loopthrough from wrong input");

    property p_lock_loss;
        @(posedge I_CLK) disable iff (rst_core)
        (!I_CDR_LOCK)[*4] |-> O_LOCK_N;
    endproperty
    a_lock_loss: assert property (p_lock_loss) else $error("lock loss not shown");

endmodule

`default_nettype wire

/* design/sdod_consts.svh */
`ifndef SDOD_CONSTS_SVH
`define SDOD_CONSTS_SVH

// register offsets
`define SDOD_REG_DEVADDR     8'h00
`define SDOD_REG_SOFT_RST    8'h01
`define SDOD_REG_STATUS      8'h02
`define SDOD_REG_SWING       8'h27
`define SDOD_REG_TIMING      8'h28

// reset values
`define SDOD_DEVADDR_RST     8'h5a
`define SDOD_SWING_RST       8'h00
`define SDOD_TIMING_RST      8'h00

// field positions
`define SDOD_SWING_HI_BIT    0
`define SDOD_TIM_DDR2_BIT    0
`define SDOD_TIM_DLY_LSB     1
`define SDOD_STAT_SEL_BIT    0
`define SDOD_STAT_FRAMED_BIT 1
`define SDOD_STAT_LOCK_BIT   2

// comma symbols (bit 9 is sent first) and idle byte
`define SDOD_COMMA_NEG       10'h0fa
`define SDOD_COMMA_POS       10'h305
`define SDOD_IDLE_BYTE       8'hbc

// timing counts
`define SDOD_COMMA_RUN       110
`define SDOD_HALF_CYC        16

`endif

/* design/sdod_pkg.sv */
`default_nettype none

package sdod_pkg;
    // output phase of the lvds clock
    typedef enum logic [1:0] {PH_IDLE, PH_RISE, PH_FALL} sdod_phase_t;
endpackage

`default_nettype wire

/* design/sdod_comma_framer.sv */
`include "sdod_consts.svh"
`default_nettype none

module sdod_comma_framer
    import sdod_pkg::*;
#(
    parameter int COMMA_RUN = `SDOD_COMMA_RUN
)(
    input  wire logic       i_clk,    // core clock
    input  wire logic       i_rst,    // sync reset, also resync on input switch
    input  wire logic [9:0] i_word,   // raw unaligned word
    input  wire logic       i_vld,    // word strobe
    output logic      [9:0] o_word,   // aligned word
    output logic            o_vld,    // aligned word strobe
    output logic            o_framed  // comma run reached
);
    logic [9:0] prev_q;
    logic [3:0] off_q;
    logic [7:0] run_q;
    logic [9:0] hit;
    logic [9:0] cand [10];
    logic [3:0] first;
    wire  [19:0] win = {prev_q, i_word};

    // candidate alignments and comma hits
    for (genvar k = 0; k < 10; k++)
    begin : g_off
        assign cand[k] = win[19-k -: 10];
        assign hit[k]  = (cand[k] == `SDOD_COMMA_NEG) || (cand[k] == `SDOD_COMMA_POS);
    end

    // lowest offset holding a comma
    always_comb
    begin
        first = 4'h0;
        for (int k = 9; k >= 0; k--)
        begin
            if (hit[k])
                first = 4'(k);
        end
    end

    assign o_framed = run_q >= 8'(COMMA_RUN);

    // alignment tracking and count of commas at the held offset; words without a comma leave the count unchanged
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            prev_q <= 10'h000;
            off_q  <= 4'h0;
            run_q  <= 8'h00;
            o_word <= 10'h000;
            o_vld  <= 1'b0;
        end
        else
        begin
            o_vld <= i_vld;
            if (i_vld)
            begin
                prev_q <= i_word;
                o_word <= cand[off_q];
                if (hit[off_q])
                begin
                    if (run_q != 8'hff)
                        run_q <= run_q + 8'h01;
                end
                else if (|hit)
                begin
                    off_q <= first;
                    run_q <= 8'h01;
                end
            end
        end
    end

    property p_framed_after_run;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_framed) |-> $past(i_vld) && ($past(run_q) == 8'(COMMA_RUN - 1));
    endproperty
    a_framed_after_run: assert property (p_framed_after_run) else $error("framed without full comma run");

    property p_realign_drops_frame;
        @(posedge i_clk) disable iff (i_rst)
        (i_vld && !hit[off_q] && (|hit)) |=> !o_framed && (off_q == $past(first));
    endproperty
    a_realign_drops_frame: assert property (p_realign_drops_frame) else $error("realign kept framing");

endmodule

`default_nettype wire

/* bench/sdod_host_model.sv */
`default_nettype none

// ---------------------------------------------
// host side capture of the five lvds lanes
// ---------------------------------------------
module sdod_host_model
(
    input  wire logic       i_clk,   // core clock
    input  wire logic       i_rst,   // sync reset, high
    input  wire logic [4:0] i_lanes, // five data lanes
    input  wire logic       i_lclk,  // lvds output clock
    output logic      [9:0] o_word,  // last {fall, rise} pair
    output logic      [7:0] o_wr_cnt // pairs written to the receive buffer
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_q;
    logic [4:0] lo_q;

    // lanes are sampled mid-cycle, where they are settled; edges come from the clock level
    always @(negedge i_clk)
    begin
        if (i_rst)
        begin
            clk_q    <= 1'b0;
            lo_q     <= 5'h00;
            o_word   <= 10'h000;
            o_wr_cnt <= 8'h00;
        end
        else
        begin
            clk_q <= i_lclk;
            if (i_lclk && !clk_q)
                lo_q <= i_lanes;
            if (!i_lclk && clk_q)
            begin
                o_word <= {i_lanes, lo_q};
                if (!lo_q[4])
                    o_wr_cnt <= o_wr_cnt + 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

/* bench/testbench.sv */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------
    // signals and instances
    // ---------------------------------------------
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       reset_n = 1'b1;
    logic       asi = 1'b0;
    logic       sel = 1'b0;
    logic [9:0] in0 = 10'h000;
    logic [9:0] in1 = 10'h000;
    logic       vld = 1'b0;
    logic       lock = 1'b0;
    logic       wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    wire  [7:0] rdata;
    wire  [7:0] dev_addr;
    wire  [4:0] lanes;
    wire        lclk;
    wire        swing_hi;
    wire  [9:0] loop_word;
    wire        lock_n;
    wire        framed;
    wire  [9:0] host_word;
    wire  [7:0] wr_cnt;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cycles = 0;
    logic [7:0] cnt0;
    logic       lclk0;

    sdod_top #(.HALF_CYC(2), .COMMA_RUN(3)) sdod_top_inst (
        .I_CLK(clk), .I_RST(rst), .I_RESET_N(reset_n), .I_ASI_MODE(asi),
        .I_SERIAL_INPUT_SELECT(sel), .I_SERIAL_INPUT_ZERO(in0), .I_SERIAL_INPUT_ONE(in1),
        .I_WORD_VLD(vld), .I_CDR_LOCK(lock), .I_REG_WR(wr), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_DEV_ADDR(dev_addr), .O_LVDS_DATA(lanes),
        .O_LVDS_OUTPUT_CLOCK(lclk), .O_LVDS_SWING_HI(swing_hi), .O_LOOP_WORD(loop_word),
        .O_LOCK_N(lock_n), .O_FRAMED(framed));

    sdod_host_model sdod_host_model_inst (
        .i_clk(clk), .i_rst(rst), .i_lanes(lanes), .i_lclk(lclk),
        .o_word(host_word), .o_wr_cnt(wr_cnt));

    // 250 MHz core clock
    always #2 clk = ~clk;

    // ---------------------------------------------
    // helper tasks
    // ---------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // read data shows one cycle after the address
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(name, 10'(rdata), 10'(exp));
    endtask

    // one recovered word; spacing keeps within one word per rise and fall pair
    task automatic send(input logic [9:0] w0, input logic [9:0] w1);
        @(negedge clk);
        vld = 1'b1;
        in0 = w0;
        in1 = w1;
        @(negedge clk);
        vld = 1'b0;
        cyc(6);
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ---------------------------------------------
    // test sequence
    // ---------------------------------------------
    initial
    begin
        cyc(6);
        rst = 1'b0;
        cyc(4);
        rd_reg(8'h00, 8'h5a, "dev_addr_rst");
        rd_reg(8'h27, 8'h00, "swing_rst");
        rd_reg(8'h28, 8'h00, "timing_rst");
        check("swing_hi_rst", 10'(swing_hi), 10'h000);
        check("lock_n_rst", 10'(lock_n), 10'h001);
        $display("test reset_values done");

        wr_reg(8'h27, 8'h01);
        check("swing_hi_set", 10'(swing_hi), 10'h001);
        wr_reg(8'h28, 8'h07);
        rd_reg(8'h28, 8'h07, "timing_rw");
        wr_reg(8'h55, 8'hff);
        rd_reg(8'h55, 8'h00, "unmapped");
        wr_reg(8'h00, 8'h33);
        wr_reg(8'h01, 8'h00);
        cyc(2);
        rd_reg(8'h27, 8'h00, "swing_soft");
        rd_reg(8'h28, 8'h00, "timing_soft");
        check("dev_addr_kept", 10'(dev_addr), 10'h033);
        $display("test registers done");

        send(10'h2a5, 10'h000);
        cyc(8);
        check("raw_lanes", host_word, 10'h2a5);
        check("loop_in0", loop_word, 10'h2a5);
        sel = 1'b1;
        cyc(4);
        send(10'h000, 10'h1c3);
        cyc(8);
        check("loop_in1", loop_word, 10'h1c3);
        check("raw_in1", host_word, 10'h1c3);
        sel = 1'b0;
        cyc(4);
        $display("test raw_mode done");

        asi = 1'b1;
        cyc(4);
        for (int i = 0; i < 8; i++)
            send(i[0] ? 10'h305 : 10'h0fa, 10'h000);
        cyc(4);
        check("framed", 10'(framed), 10'h001);
        check("idle_pair", host_word, {5'h1b, 5'h1c});
        cnt0 = wr_cnt;
        repeat (3) send(10'h2aa, 10'h000);
        cyc(2);
        check("data_pair", host_word, {5'h0b, 5'h05});
        send(10'h2aa, 10'h000);
        send(10'h0fa, 10'h000);
        send(10'h305, 10'h000);
        cyc(8);
        check("fifo_writes", 10'(wr_cnt - cnt0), 10'h004);
        check("idle_again", host_word, {5'h1b, 5'h1c});
        $display("test decode_mode done");

        // an input switch drops framing; then the half rate clock toggles once per word
        sel = 1'b1;
        cyc(4);
        check("framed_drop", 10'(framed), 10'h000);
        sel = 1'b0;
        wr_reg(8'h28, 8'h07);
        cyc(4);
        lclk0 = lclk;
        send(10'h2aa, 10'h000);
        cyc(4);
        check("half_rate_clk", 10'(lclk), 10'(!lclk0));
        $display("test ddr2_clock done");

        lock = 1'b1;
        cyc(5);
        check("lock_n_low", 10'(lock_n), 10'h000);
        rd_reg(8'h02, 8'h04, "status_lock");
        lock = 1'b0;
        cyc(5);
        check("lock_n_high", 10'(lock_n), 10'h001);
        $display("test lock done");

        wr_reg(8'h27, 8'h01);
        reset_n = 1'b0;
        cyc(5);
        check("pin_swing", 10'(swing_hi), 10'h000);
        check("pin_addr", 10'(dev_addr), 10'h05a);
        check("pin_lanes", 10'(lanes), 10'h000);
        reset_n = 1'b1;
        cyc(5);
        wr_reg(8'h27, 8'h01);
        check("pin_resume", 10'(swing_hi), 10'h001);
        $display("test reset_pin done");
        stop_test();
    end
endmodule

`default_nettype wire
